/* bench/cpu_register_set_monitor.sv */
// Port checker for the register set.
// Assumes one clock domain and an asynchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module cpu_register_set_monitor
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Register bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  // Unit requests
  input wire logic        sr_we,
  input wire logic [15:0] sr_wdata,
  input wire logic        ctl_we,
  input wire logic        instr_done,
  input wire logic        instr_flow,
  input wire logic        bus_cycle,
  input wire logic        bus_prog,
  input wire logic [1:0]  bus_alt,
  // Watched outputs
  input wire logic [2:0]  space_code_outputs,
  input wire logic [15:0] processor_status_word_reg,
  input wire logic [31:0] exception_table_base_reg,
  input wire logic [2:0]  source_space_code_reg,
  input wire logic [2:0]  dest_space_code_reg,
  input wire logic        trace_trap,
  input wire logic        priv_trap
);
  logic [15:0] psw;      // Short alias of the status word
  logic [2:0]  exp_code; // Code the next bus cycle must show
  assign psw = processor_status_word_reg;
  // Alternate codes only count in supervisor state
  always_comb
  begin
    if (psw[13] && bus_alt == 2'h1)
      exp_code = source_space_code_reg;
    else if (psw[13] && bus_alt == 2'h2)
      exp_code = dest_space_code_reg;
    else
      exp_code = {psw[13], bus_prog, !bus_prog};
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Setup cycle, then first access cycle
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence first_access_s;
    psel && penable;
  endsequence
  apb_wait_a: assert property (setup_s ##1 first_access_s |-> !pready ##1 pready)
    else $error("ready not after one wait cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  err_with_ready_a: assert property (pslverr |-> pready && psel && penable)
    else $error("error flag outside a completing access");
  trace_cause_a: assert property (
    trace_trap == $past(instr_done && (psw[14] || (psw[15] && instr_flow))))
    else $error("trace trap does not match its cause");
  priv_trap_a: assert property ((sr_we || ctl_we) && !psw[13] |=> priv_trap)
    else $error("refused write without trap");
  priv_hold_a: assert property (ctl_we && !psw[13] |=>
    $stable(exception_table_base_reg) && $stable(source_space_code_reg)
    && $stable(dest_space_code_reg))
    else $error("control register changed in user state");
  sr_write_a: assert property (sr_we && psw[13] |=>
    psw == $past(sr_wdata & cpu_regs_pkg::SR_IMPL))
    else $error("status write lost");
  code_next_a: assert property (bus_cycle |=> space_code_outputs == $past(exp_code))
    else $error("wrong space code");
  code_hold_a: assert property (!bus_cycle |=> $stable(space_code_outputs))
    else $error("space code moved between bus cycles");
endmodule : cpu_register_set_monitor
bind cpu_register_set cpu_register_set_monitor u_cpu_register_set_monitor (.*);
`default_nettype wire

/* bench/cpu_register_set_tb.sv */
// Self-checking bench: APB master tasks plus the unit model.
// Assumes the checker is bound into the design by its own file.
`timescale 1ns/1ps
`default_nettype none
module cpu_register_set_tb;
  // Design ports
  logic clk, rst, psel, penable, pwrite, pready, pslverr, irq, eu_we, pc_we, cc_we;
  logic sr_we, ctl_we, instr_done, instr_flow, bus_cycle, bus_prog, trace_trap, priv_trap;
  logic [1:0] bus_alt;
  logic [2:0] eu_op, ctl_sel, space_code_outputs, source_space_code_reg, dest_space_code_reg;
  logic [3:0] eu_idx, eu_rd_idx, eu_index_idx;
  logic [4:0] eu_bf_off, eu_bf_w, cc_wdata;
  logic [7:0] paddr;
  logic [15:0] sr_wdata, processor_status_word_reg;
  logic [31:0] pwdata, prdata, eu_wdata, eu_wdata_hi, eu_rd_data, eu_index_data, pc_wdata;
  logic [31:0] ctl_wdata, pc_reg, exception_table_base_reg, icache_control_reg;
  logic [31:0] icache_address_hold_reg, active_sp_reg, q;
  logic e;
  int miscompares, n_checks, i;
  // Unit writes: {op, register, data, offset, expected}
  localparam logic [78:0] WRC [11] = '{
    {3'h0, 4'h2, 32'h1234_5678, 8'h08, 32'h1234_5678},
    {3'h2, 4'h2, 32'h0000_00AB, 8'h08, 32'h1234_56AB},
    {3'h1, 4'h2, 32'h0000_CDEF, 8'h08, 32'h1234_CDEF},
    {3'h1, 4'h8, 32'h0000_8001, 8'h20, 32'hFFFF_8001},
    {3'h0, 4'h3, 32'h0000_0000, 8'h0C, 32'h0000_0000},
    {3'h4, 4'h3, 32'hFFFF_FFFF, 8'h0C, 32'hC000_0003},
    {3'h0, 4'h4, 32'h0000_0000, 8'h10, 32'h0000_0000},
    {3'h5, 4'h4, 32'h0000_0504, 8'h10, 32'h0000_0054},
    {3'h0, 4'h5, 32'h0000_0000, 8'h14, 32'h0000_0000},
    {3'h6, 4'h5, 32'h0000_0097, 8'h14, 32'h0000_0907},
    {3'h3, 4'h7, 32'h1111_1111, 8'h1C, 32'h1111_1111}};
  // Bus cycles: {status, program, alternate, expected code}
  localparam logic [27:0] BUS [6] = '{28'h0000011, 28'h0000122, 28'h2000106,
    28'h2000005, 28'h2000017, 28'h2000123};
  cpu_register_set u_cpu_register_set (.*);
  exec_unit_model u_exec_unit_model (.*);
  // Free-running 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; result left in q and e
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    {q, e} = {prdata, pslverr};
    {psel, penable} <= 2'h0;
    @(posedge clk);
    if (n >= 20)
    begin
      miscompares++;
      close_out();
    end
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rd
  // Main sequence
  initial
  begin
    {rst, psel, penable, pwrite, pc_we, cc_we} = 6'h20;
    {paddr, pwdata, pc_wdata, cc_wdata, eu_rd_idx, eu_index_idx} = 85'h0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(cpu_regs_pkg::OFF_PSW, 32'h0000_2700);
    rd(cpu_regs_pkg::OFF_VBR, 32'h0000_0000);
    for (i = 0; i < 5; i++)
    begin
      apb(1'b1, cpu_regs_pkg::OFF_VBR + 8'(4 * i), 32'hA5A5_5A5F);
      rd(cpu_regs_pkg::OFF_VBR + 8'(4 * i), (i == 1 || i == 2) ? 32'h7 : 32'hA5A5_5A5F);
    end
    apb(1'b1, 8'h70, 32'hFFFF_FFFF);
    chk({31'h0, e}, 32'h1);
    apb(1'b0, 8'h52, 32'h0);
    chk({q[30:0], e}, 32'h1);
    $display("register bus test done");
    for (i = 0; i < 11; i++)
    begin
      u_exec_unit_model.unit_wr(WRC[i][78:76], WRC[i][75:72], WRC[i][71:40]);
      rd(WRC[i][39:32], WRC[i][31:0]);
    end
    rd(8'h00, 32'h2222_2222);
    eu_rd_idx <= 4'h2;
    eu_index_idx <= 4'h8;
    repeat (2) @(posedge clk);
    chk(eu_rd_data, 32'h1234_CDEF);
    chk(eu_index_data, 32'hFFFF_8001);
    $display("unit write test done");
    for (i = 0; i < 3; i++)
      apb(1'b1, cpu_regs_pkg::OFF_USP + 8'(4 * i), 32'h100 * (i + 1));
    for (i = 0; i < 3; i++)
    begin
      apb(1'b1, cpu_regs_pkg::OFF_PSW, (i == 2) ? 32'h0 : 32'h2000 + 32'h1000 * i);
      @(posedge clk);
      chk(active_sp_reg, (i == 2) ? 32'h100 : 32'h200 + 32'h100 * i);
    end
    u_exec_unit_model.ctl_wr(3'h0, 32'h0BAD_0BAD);
    chk(exception_table_base_reg, 32'hA5A5_5A5F);
    u_exec_unit_model.sr_wr(16'h2000);
    chk({16'h0, processor_status_word_reg}, 32'h0);
    rd(cpu_regs_pkg::OFF_ISTAT, 32'h2);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, cpu_regs_pkg::OFF_IMASK, 32'h3);
    @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, cpu_regs_pkg::OFF_ISTAT, 32'h2);
    @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    $display("privilege and interrupt test done");
    for (i = 0; i < 6; i++)
    begin
      apb(1'b1, cpu_regs_pkg::OFF_PSW, {16'h0, BUS[i][27:12]});
      if (i == 2)
        u_exec_unit_model.ctl_wr(3'h2, 32'h3);
      u_exec_unit_model.bus_start(BUS[i][8], BUS[i][5:4]);
      chk({29'h0, space_code_outputs}, {29'h0, BUS[i][2:0]});
    end
    u_exec_unit_model.sr_wr(16'hFFFF);
    chk({16'h0, processor_status_word_reg}, 32'h0000_F71F);
    {pc_we, pc_wdata, cc_we, cc_wdata} <= {1'b1, 32'hC0DE_0004, 1'b1, 5'h15};
    @(posedge clk);
    {pc_we, cc_we} <= 2'h0;
    rd(cpu_regs_pkg::OFF_PC, 32'hC0DE_0004);
    rd(cpu_regs_pkg::OFF_PSW, 32'h0000_F715);
    $display("space code test done");
    for (i = 0; i < 3; i++)
    begin
      apb(1'b1, cpu_regs_pkg::OFF_PSW, (i == 0) ? 32'h6000 : 32'hA000);
      u_exec_unit_model.done(i == 2);
      chk({31'h0, trace_trap}, (i == 1) ? 32'h0 : 32'h1);
    end
    $display("trace test done");
    close_out();
  end
endmodule : cpu_register_set_tb
`default_nettype wire

/* bench/exec_unit_model.sv */
// Execution unit stand-in driving the unit side of the register set.
// Assumes each task is called just after a rising edge of clk.
`timescale 1ns/1ps
`default_nettype none
module exec_unit_model
(
  // Clock
  input  wire logic   clk,
  // Register file writes
  output logic        eu_we,
  output logic [2:0]  eu_op,
  output logic [3:0]  eu_idx,
  output logic [31:0] eu_wdata,
  output logic [31:0] eu_wdata_hi,
  output logic [4:0]  eu_bf_off,
  output logic [4:0]  eu_bf_w,
  // Status and control writes
  output logic        sr_we,
  output logic [15:0] sr_wdata,
  output logic        ctl_we,
  output logic [2:0]  ctl_sel,
  output logic [31:0] ctl_wdata,
  // Completion and bus cycles
  output logic        instr_done,
  output logic        instr_flow,
  output logic        bus_cycle,
  output logic        bus_prog,
  output logic [1:0]  bus_alt
);
  // Idle levels; quad upper word and field placement stay fixed
  initial
  begin
    {eu_we, sr_we, ctl_we, instr_done, bus_cycle, instr_flow, bus_prog} = 7'h00;
    {eu_op, ctl_sel, eu_idx, bus_alt} = 12'h000;
    {eu_wdata, ctl_wdata, sr_wdata} = 80'h0;
    eu_wdata_hi = 32'h2222_2222;
    eu_bf_off = 5'h1E;
    eu_bf_w = 5'h04;
  end
  // Drop strobes and scramble data so stale values never pass
  task automatic settle;
    @(posedge clk);
    {eu_we, sr_we, ctl_we, instr_done, bus_cycle} <= 5'h00;
    eu_wdata <= ~eu_wdata;
    ctl_wdata <= ~ctl_wdata;
    sr_wdata <= ~sr_wdata;
    @(posedge clk);
  endtask : settle
  task automatic unit_wr(input logic [2:0] op, input logic [3:0] idx, input logic [31:0] d);
    {eu_op, eu_idx, eu_wdata, eu_we} <= {op, idx, d, 1'b1};
    settle();
  endtask : unit_wr
  task automatic ctl_wr(input logic [2:0] sel, input logic [31:0] d);
    {ctl_sel, ctl_wdata, ctl_we} <= {sel, d, 1'b1};
    settle();
  endtask : ctl_wr
  task automatic sr_wr(input logic [15:0] d);
    {sr_wdata, sr_we} <= {d, 1'b1};
    settle();
  endtask : sr_wr
  task automatic done(input logic flow);
    {instr_flow, instr_done} <= {flow, 1'b1};
    settle();
  endtask : done
  task automatic bus_start(input logic prog, input logic [1:0] alt);
    {bus_prog, bus_alt, bus_cycle} <= {prog, alt, 1'b1};
    settle();
  endtask : bus_start
endmodule : exec_unit_model
`default_nettype wire

/* design/cpu_register_set.sv */
// Programmer-visible register set with APB debug slave.
// Assumes a same-clock execution unit; its writes beat APB.
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module cpu_register_set
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // APB slave
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  // Register file write port
  input  wire logic         eu_we,
  input  wire logic [2:0]   eu_op,
  input  wire logic [3:0]   eu_idx,
  input  wire logic [31:0]  eu_wdata,
  input  wire logic [31:0]  eu_wdata_hi,
  input  wire logic [4:0]   eu_bf_off,
  input  wire logic [4:0]   eu_bf_w,
  // Register file read ports
  input  wire logic [3:0]   eu_rd_idx,
  output logic [31:0]       eu_rd_data,
  input  wire logic [3:0]   eu_index_idx,
  output logic [31:0]       eu_index_data,
  // Program counter and status updates
  input  wire logic         pc_we,
  input  wire logic [31:0]  pc_wdata,
  input  wire logic         cc_we,
  input  wire logic [4:0]   cc_wdata,
  input  wire logic         sr_we,
  input  wire logic [15:0]  sr_wdata,
  // Control register updates
  input  wire logic         ctl_we,
  input  wire logic [2:0]   ctl_sel,
  input  wire logic [31:0]  ctl_wdata,
  // Instruction completion
  input  wire logic         instr_done,
  input  wire logic         instr_flow,
  // Bus cycle start
  input  wire logic         bus_cycle,
  input  wire logic         bus_prog,
  input  wire logic [1:0]   bus_alt,
  output logic [2:0]        space_code_outputs,
  // Register contents
  output logic [31:0]       pc_reg,
  output logic [15:0]       processor_status_word_reg,
  output logic [31:0]       exception_table_base_reg,
  output logic [2:0]        source_space_code_reg,
  output logic [2:0]        dest_space_code_reg,
  output logic [31:0]       icache_control_reg,
  output logic [31:0]       icache_address_hold_reg,
  output logic [31:0]       active_sp_reg,
  // Traps and interrupt
  output logic              trace_trap,
  output logic              priv_trap,
  output logic              irq
);
  // Rotate left within a 32-bit register
  function automatic logic [31:0] rotl(input logic [31:0] v,
                                       input logic [4:0]  n);
    logic [63:0] t;
    t = {v, v} << n;
    return t[63:32];
  endfunction : rotl
  // Field mask; width zero means 32 bits
  function automatic logic [31:0] fmask(input logic [4:0] off,
                                        input logic [4:0] w);
    logic [31:0] m;
    m = (w == 5'h00) ? 32'hFFFF_FFFF
                     : ((32'h0000_0001 << w) - 32'h0000_0001);
    return rotl(m, off);
  endfunction : fmask
  // Merge a write into the old register value
  function automatic logic [31:0] merge(input logic [2:0]  op,
                                        input logic [31:0] old,
                                        input logic [31:0] d,
                                        input logic        is_a,
                                        input logic [4:0]  off,
                                        input logic [4:0]  w);
    logic [31:0] m;
    logic [31:0] r;
    m = fmask(off, w);
    case (op)
      // Address registers take the word sign-extended
      cpu_regs_pkg::OP_WORD:
        r = is_a ? {{16{d[15]}}, d[15:0]} : {old[31:16], d[15:0]};
      cpu_regs_pkg::OP_BYTE:   r = {old[31:8], d[7:0]};
      cpu_regs_pkg::OP_FIELD:  r = (old & ~m) | (rotl(d, off) & m);
      // Two one-digit bytes squeezed into one byte
      cpu_regs_pkg::OP_PACK:   r = {old[31:8], d[11:8], d[3:0]};
      // One byte spread into two one-digit bytes
      cpu_regs_pkg::OP_UNPACK:
        r = {old[31:16], 4'h0, d[7:4], 4'h0, d[3:0]};
      default:                 r = d;
    endcase
    return r;
  endfunction : merge
  // Data and address registers; slot 15 is the stack pointer
  logic [31:0] gp_reg [0:14];
  logic [31:0] usp_reg, isp_reg, msp_reg; // Stack pointers
  logic [cpu_regs_pkg::IRQ_W-1:0] irq_stat_reg, irq_mask_reg; // Event status and mask
  // Combined view of all sixteen registers
  logic [31:0] gp_view [0:15];
  logic [31:0] sp_now;
  logic [31:0] sp_wr;   // Active stack pointer after a unit write
  // APB decode
  logic        apb_fire;
  logic        apb_hit;
  logic        apb_wr;
  logic [31:0] apb_rd;
  // Privilege and events
  logic        sup;
  logic        eu_wr_hi;
  logic        priv_ev;
  logic        trace_ev;
  logic [cpu_regs_pkg::IRQ_W-1:0] irq_set;
  // Supervisor state bit
  assign sup = processor_status_word_reg[cpu_regs_pkg::SR_S];
  // Active stack pointer by supervisor and master bits
  always_comb
  begin
    if (!sup)
      sp_now = usp_reg;
    else if (processor_status_word_reg[cpu_regs_pkg::SR_M])
      sp_now = msp_reg;
    else
      sp_now = isp_reg;
  end
  // Register view: slot 15 is the active stack pointer
  generate
    for (genvar gi = 0; gi < 15; gi++)
    begin : g_view
      assign gp_view[gi] = gp_reg[gi];
    end
  endgenerate
  assign gp_view[15] = sp_now;
  // Unit write merged into the active stack pointer
  assign sp_wr = merge(eu_op, sp_now, eu_wdata, 1'b1, eu_bf_off, eu_bf_w);
  // APB access completes on the second access cycle
  assign apb_fire = psel & penable & pready;
  assign apb_wr   = apb_fire & pwrite & apb_hit;
  // APB address decode and read mux
  always_comb
  begin
    apb_rd  = 32'h0000_0000;
    apb_hit = 1'b1;
    if (paddr[1:0] != 2'h0)
      apb_hit = 1'b0;
    else if (paddr <= cpu_regs_pkg::OFF_GP_HI)
      apb_rd = gp_view[paddr[5:2]];
    else if (paddr == cpu_regs_pkg::OFF_PC)
      apb_rd = pc_reg;
    else if (paddr == cpu_regs_pkg::OFF_USP)
      apb_rd = usp_reg;
    else if (paddr == cpu_regs_pkg::OFF_ISP)
      apb_rd = isp_reg;
    else if (paddr == cpu_regs_pkg::OFF_MSP)
      apb_rd = msp_reg;
    else if (paddr == cpu_regs_pkg::OFF_PSW)
      apb_rd = {16'h0000, processor_status_word_reg};
    else if (paddr == cpu_regs_pkg::OFF_VBR)
      apb_rd = exception_table_base_reg;
    else if (paddr == cpu_regs_pkg::OFF_SRC)
      apb_rd = {29'h0000_0000, source_space_code_reg};
    else if (paddr == cpu_regs_pkg::OFF_DST)
      apb_rd = {29'h0000_0000, dest_space_code_reg};
    else if (paddr == cpu_regs_pkg::OFF_CCTL)
      apb_rd = icache_control_reg;
    else if (paddr == cpu_regs_pkg::OFF_CADR)
      apb_rd = icache_address_hold_reg;
    else if (paddr == cpu_regs_pkg::OFF_ISTAT)
      apb_rd = {30'h0000_0000, irq_stat_reg};
    else if (paddr == cpu_regs_pkg::OFF_IMASK)
      apb_rd = {30'h0000_0000, irq_mask_reg};
    else
      apb_hit = 1'b0;
  end
  // APB handshake: one wait state, then ready with data
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~apb_hit;
      // Unmapped reads return zero
      if (psel & penable & ~pready & ~pwrite)
        prdata <= apb_rd;
    end
  end
  // Privileged writes from user state are refused
  assign priv_ev = (sr_we | ctl_we) & ~sup;
  // Quad writes also fill the next data register
  assign eu_wr_hi = eu_we & (eu_op == cpu_regs_pkg::OP_QUAD) & ~eu_idx[3];
  // General registers: APB first, unit write lands last
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < 15; i++)
        gp_reg[i] <= cpu_regs_pkg::W32_RST;
    end
    else
    begin
      if (apb_wr && paddr < cpu_regs_pkg::OFF_GP_HI)
        gp_reg[paddr[5:2]] <= pwdata;
      if (eu_we && eu_idx != cpu_regs_pkg::IDX_SP)
        gp_reg[eu_idx] <= merge(eu_op, gp_reg[eu_idx], eu_wdata,
                                eu_idx[3], eu_bf_off, eu_bf_w);
      // Upper long of a quad goes to the paired data register
      if (eu_wr_hi)
        gp_reg[{1'b0, eu_idx[2:0] + 3'h1}] <= eu_wdata_hi;
    end
  end
  // Stack pointers: slot 15 writes the active one
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      usp_reg <= cpu_regs_pkg::W32_RST;
      isp_reg <= cpu_regs_pkg::W32_RST;
      msp_reg <= cpu_regs_pkg::W32_RST;
    end
    else
    begin
      if (apb_wr && paddr == cpu_regs_pkg::OFF_USP)
        usp_reg <= pwdata;
      if (apb_wr && paddr == cpu_regs_pkg::OFF_ISP)
        isp_reg <= pwdata;
      if (apb_wr && paddr == cpu_regs_pkg::OFF_MSP)
        msp_reg <= pwdata;
      if (eu_we && eu_idx == cpu_regs_pkg::IDX_SP)
      begin
        // Stack pointer accepts word and long forms
        if (!sup)
          usp_reg <= sp_wr;
        else if (processor_status_word_reg[cpu_regs_pkg::SR_M])
          msp_reg <= sp_wr;
        else
          isp_reg <= sp_wr;
      end
    end
  end
  // Program counter
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pc_reg <= cpu_regs_pkg::W32_RST;
    else if (pc_we)
      pc_reg <= pc_wdata;
    else if (apb_wr && paddr == cpu_regs_pkg::OFF_PC)
      pc_reg <= pwdata;
  end
  // Status word: unit full write needs supervisor, APB full write does not, flags X N Z V C always
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      processor_status_word_reg <= cpu_regs_pkg::SR_RST;
    else if (sr_we && sup)
      processor_status_word_reg <= sr_wdata & cpu_regs_pkg::SR_IMPL;
    else if (cc_we)
      processor_status_word_reg[cpu_regs_pkg::SR_CC_W-1:0] <= cc_wdata;
    else if (apb_wr && paddr == cpu_regs_pkg::OFF_PSW)
      processor_status_word_reg <= pwdata[15:0] & cpu_regs_pkg::SR_IMPL;
  end
  // Exception table base
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      exception_table_base_reg <= cpu_regs_pkg::W32_RST;
    else if (ctl_we && sup && ctl_sel == cpu_regs_pkg::CTL_VBR)
      exception_table_base_reg <= ctl_wdata;
    else if (apb_wr && paddr == cpu_regs_pkg::OFF_VBR)
      exception_table_base_reg <= pwdata;
  end
  // Alternate space codes
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      source_space_code_reg <= cpu_regs_pkg::SPC_RST;
      dest_space_code_reg   <= cpu_regs_pkg::SPC_RST;
    end
    else
    begin
      if (ctl_we && sup && ctl_sel == cpu_regs_pkg::CTL_SRC)
        source_space_code_reg <= ctl_wdata[2:0];
      else if (apb_wr && paddr == cpu_regs_pkg::OFF_SRC)
        source_space_code_reg <= pwdata[2:0];
      if (ctl_we && sup && ctl_sel == cpu_regs_pkg::CTL_DST)
        dest_space_code_reg <= ctl_wdata[2:0];
      else if (apb_wr && paddr == cpu_regs_pkg::OFF_DST)
        dest_space_code_reg <= pwdata[2:0];
    end
  end
  // Cache control and address hold
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      icache_control_reg      <= cpu_regs_pkg::W32_RST;
      icache_address_hold_reg <= cpu_regs_pkg::W32_RST;
    end
    else
    begin
      if (ctl_we && sup && ctl_sel == cpu_regs_pkg::CTL_CCTL)
        icache_control_reg <= ctl_wdata;
      else if (apb_wr && paddr == cpu_regs_pkg::OFF_CCTL)
        icache_control_reg <= pwdata;
      if (ctl_we && sup && ctl_sel == cpu_regs_pkg::CTL_CADR)
        icache_address_hold_reg <= ctl_wdata;
      else if (apb_wr && paddr == cpu_regs_pkg::OFF_CADR)
        icache_address_hold_reg <= pwdata;
    end
  end
  // Registered read ports and active stack pointer copy
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      eu_rd_data    <= cpu_regs_pkg::W32_RST;
      eu_index_data <= cpu_regs_pkg::W32_RST;
      active_sp_reg <= cpu_regs_pkg::W32_RST;
    end
    else
    begin
      active_sp_reg <= sp_now;
      eu_rd_data    <= gp_view[eu_rd_idx];
      // Any of the sixteen can serve as index
      eu_index_data <= gp_view[eu_index_idx];
    end
  end
  // Trace trap after completed instructions
  assign trace_ev = instr_done &
    (processor_status_word_reg[cpu_regs_pkg::SR_TRACE_EVERY] |
     (processor_status_word_reg[cpu_regs_pkg::SR_TRACE_FLOW] & instr_flow));
  // Trap pulses
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      trace_trap <= 1'b0;
      priv_trap  <= 1'b0;
    end
    else
    begin
      trace_trap <= trace_ev;
      priv_trap  <= priv_ev;
    end
  end
  // Space code for each bus cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      space_code_outputs <= cpu_regs_pkg::SPC_RST;
    else if (bus_cycle && sup && bus_alt == cpu_regs_pkg::ALT_SRC)
      space_code_outputs <= source_space_code_reg;
    else if (bus_cycle && sup && bus_alt == cpu_regs_pkg::ALT_DST)
      space_code_outputs <= dest_space_code_reg;
    else if (bus_cycle && sup)
      space_code_outputs <= bus_prog ? cpu_regs_pkg::SPC_SUP_PROG
                                     : cpu_regs_pkg::SPC_SUP_DATA;
    else if (bus_cycle)
      space_code_outputs <= bus_prog ? cpu_regs_pkg::SPC_USER_PROG
                                     : cpu_regs_pkg::SPC_USER_DATA;
  end
  // Sticky event bits: a new event beats a clear
  assign irq_set[cpu_regs_pkg::IRQ_TRACE] = trace_ev;
  assign irq_set[cpu_regs_pkg::IRQ_PRIV]  = priv_ev;
  // Interrupt status, write one to clear
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      irq_stat_reg <= '0;
    else if (apb_wr && paddr == cpu_regs_pkg::OFF_ISTAT)
      irq_stat_reg <= (irq_stat_reg & ~pwdata[cpu_regs_pkg::IRQ_W-1:0]) | irq_set;
    else
      irq_stat_reg <= irq_stat_reg | irq_set;
  end
  // Interrupt mask
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      irq_mask_reg <= '0;
    else if (apb_wr && paddr == cpu_regs_pkg::OFF_IMASK)
      irq_mask_reg <= pwdata[cpu_regs_pkg::IRQ_W-1:0];
  end
  // Level interrupt from unmasked status
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= |(irq_stat_reg & irq_mask_reg);
  end
endmodule : cpu_register_set
`default_nettype wire

/* include/cpu_regs_pkg.sv */
// Constants for the programmer-visible register set.
// Assumes APB debug access and a same-clock execution unit.
//
// Summary of operation
// - Eight data, eight address registers, 32-bit
// - Program counter plus user/interrupt/master stacks
// - Sixteen-bit status word: flags and control
// - Exception table base register, 32-bit
// - Source and destination space codes, 3-bit
// - Data writes: field, byte, long, quad
// - Address registers: stack/base, word and long
// - Any of sixteen registers readable as index
// - Status: priority mask plus five condition flags
// - Status: two trace, supervisor, master bits
// - Every-instruction trace traps after each instruction
// - Flow trace traps after change of flow
// - Space code outputs driven every bus cycle
// - Supervisor may emit alternate source/destination code
// - Cache control and address hold registers
// - Packed and unpacked decimal digit conversion
package cpu_regs_pkg;
  // APB register byte offsets
  localparam logic [7:0] OFF_GP_HI  = 8'h3C;
  localparam logic [7:0] OFF_PC     = 8'h40;
  localparam logic [7:0] OFF_USP    = 8'h44;
  localparam logic [7:0] OFF_ISP    = 8'h48;
  localparam logic [7:0] OFF_MSP    = 8'h4C;
  localparam logic [7:0] OFF_PSW    = 8'h50;
  localparam logic [7:0] OFF_VBR    = 8'h54;
  localparam logic [7:0] OFF_SRC    = 8'h58;
  localparam logic [7:0] OFF_DST    = 8'h5C;
  localparam logic [7:0] OFF_CCTL   = 8'h60;
  localparam logic [7:0] OFF_CADR   = 8'h64;
  localparam logic [7:0] OFF_ISTAT  = 8'h68;
  localparam logic [7:0] OFF_IMASK  = 8'h6C;
  // Status word fields
  localparam int SR_TRACE_FLOW  = 15;
  localparam int SR_TRACE_EVERY = 14;
  localparam int SR_S  = 13;
  localparam int SR_M  = 12;
  localparam int SR_IPM_LO = 8;
  localparam int SR_CC_W = 5;
  localparam logic [15:0] SR_IMPL = 16'hF71F;
  // Reset values
  localparam logic [15:0] SR_RST  = 16'h2700;
  localparam logic [31:0] W32_RST = 32'h0000_0000;
  localparam logic [2:0]  SPC_RST = 3'h0;
  // Space codes
  localparam logic [2:0] SPC_USER_DATA = 3'h1;
  localparam logic [2:0] SPC_USER_PROG = 3'h2;
  localparam logic [2:0] SPC_SUP_DATA  = 3'h5;
  localparam logic [2:0] SPC_SUP_PROG  = 3'h6;
  // Interrupt status bits
  localparam int IRQ_TRACE = 0;
  localparam int IRQ_PRIV  = 1;
  localparam int IRQ_W     = 2;
  // Index of the active stack pointer
  localparam logic [3:0] IDX_SP = 4'hF;
  // Execution unit write operations
  typedef enum logic [2:0] {
    OP_LONG   = 3'h0,
    OP_WORD   = 3'h1,
    OP_BYTE   = 3'h2,
    OP_QUAD   = 3'h3,
    OP_FIELD  = 3'h4,
    OP_PACK   = 3'h5,
    OP_UNPACK = 3'h6
  } eu_op_t;
  // Control register selector
  typedef enum logic [2:0] {
    CTL_VBR  = 3'h0,
    CTL_SRC  = 3'h1,
    CTL_DST  = 3'h2,
    CTL_CCTL = 3'h3,
    CTL_CADR = 3'h4
  } ctl_sel_t;
  // Alternate space request
  typedef enum logic [1:0] {
    ALT_NONE = 2'h0,
    ALT_SRC  = 2'h1,
    ALT_DST  = 2'h2
  } alt_t;
endpackage : cpu_regs_pkg
